// >>> ppr_pkg.sv
// Constants and types shared by the pump run permit supervisor
`default_nettype none

package ppr_pkg;

  // ---------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;   // System clock rate
  localparam int TICK_SEC    = 1;            // Time base step, seconds
  localparam int TICK_CYCLES = CLK_HZ * TICK_SEC;
  localparam int PRE_W       = 26;           // Prescaler width
  localparam int SEC_W       = 12;           // Seconds counter width
  localparam int SEC_PER_MIN = 60;

  // ---------------------------------------------------------------
  // Delay figures in minutes, and derived second counts
  // ---------------------------------------------------------------
  localparam int DLY_REMOTE_MIN = 1;   // Remote contact default
  localparam int DLY_PROBE_MIN  = 3;   // Water probe default
  localparam int DLY_SW3_MIN    = 10;  // Lengthened by switch 3
  localparam int DLY_SW4_MIN    = 30;  // Lengthened by switch 4
  localparam int OC_HOLD_MIN    = 3;   // Over-current hold off

  localparam logic [SEC_W-1:0] DLY_REMOTE_SEC =
    SEC_W'(DLY_REMOTE_MIN * SEC_PER_MIN);
  localparam logic [SEC_W-1:0] DLY_PROBE_SEC =
    SEC_W'(DLY_PROBE_MIN * SEC_PER_MIN);
  localparam logic [SEC_W-1:0] DLY_SW3_SEC =
    SEC_W'(DLY_SW3_MIN * SEC_PER_MIN);
  localparam logic [SEC_W-1:0] DLY_SW4_SEC =
    SEC_W'(DLY_SW4_MIN * SEC_PER_MIN);
  localparam logic [SEC_W-1:0] OC_HOLD_SEC =
    SEC_W'(OC_HOLD_MIN * SEC_PER_MIN);

  // Screen step interval and low-power start grace, in seconds
  localparam logic [3:0] SCREEN_STEP_SEC = 4'h3;
  localparam logic [3:0] LP_GRACE_SEC    = 4'h5;

  // ---------------------------------------------------------------
  // Configuration switch bit positions (switch n is bit n-1)
  // ---------------------------------------------------------------
  localparam int SW_REMOTE_POL = 0;
  localparam int SW_PROBE_POL  = 1;
  localparam int SW_DLY_10     = 2;
  localparam int SW_DLY_30     = 3;
  localparam int SW_FREEZE     = 6;

  localparam int ADC_W = 12;           // Power and trim input width

  // ---------------------------------------------------------------
  // Display screens and status messages
  // ---------------------------------------------------------------
  localparam logic [2:0] SCR_STARTUP = 3'h0;  // Identification screen
  localparam logic [2:0] SCR_FIRST   = 3'h1;  // Status screen
  localparam logic [2:0] SCR_LAST    = 3'h5;  // Power screen

  localparam logic [1:0] MSG_NONE     = 2'h0;
  localparam logic [1:0] MSG_OVER_CUR = 2'h1;
  localparam logic [1:0] MSG_LOW_PWR  = 2'h2;
  localparam logic [1:0] MSG_EXT_STOP = 2'h3;

  // Permit states, Gray coded along stop, delay, run, hold
  typedef enum logic [1:0] {
    ST_STOPPED = 2'h0,
    ST_DELAY   = 2'h1,
    ST_RUN     = 2'h3,
    ST_OC_HOLD = 2'h2
  } ppr_state_t;

endpackage : ppr_pkg

`default_nettype wire

// >>> ppr_hold_timer.sv
// Seconds down-counter with its own prescaler, used for timed holds
`timescale 1ns/10ps
`default_nettype none

module ppr_hold_timer #(
  parameter int TICK_CYCLES = ppr_pkg::TICK_CYCLES
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_load,
  input  wire logic [ppr_pkg::SEC_W-1:0] i_load_sec,
  output logic                           o_busy
);
  import ppr_pkg::*;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  logic [PRE_W-1:0] pre_reg;
  logic [SEC_W-1:0] sec_reg;

  // Load restarts a whole second; otherwise count down to zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_reg <= '0;
      sec_reg <= '0;
    end else if (i_load) begin
      pre_reg <= '0;
      sec_reg <= i_load_sec;
    end else if (sec_reg != '0) begin
      if (pre_reg == PRE_LAST) begin
        pre_reg <= '0;
        sec_reg <= sec_reg - SEC_W'(1);
      end else begin
        pre_reg <= pre_reg + PRE_W'(1);
      end
    end
  end

  assign o_busy = (sec_reg != '0);

endmodule : ppr_hold_timer

`default_nettype wire

// >>> ppr_run_permit.sv
// Pump run permit supervisor: stop inputs, timers, faults and display
//
// Summary of operation
// - Switch 1 off: closed remote contact stops; on: closed contact runs.
// - Switch 2 off: probe path to ground stops; on: path required.
// - One restart timer serves remote and probe; remote default one minute.
// - Switch 3 on lengthens the restart delay to ten minutes.
// - Switch 4 on lengthens the restart delay to thirty minutes.
// - Switch 7 off: screens step at a fixed interval.
// - Switch 7 on: screen stops on whichever was current.
// - Over-current stops motor, holds off three minutes, then retries.
// - Over-current shutdown lights error indicator and selects its message.
// - Over-current after retry repeats the three-minute hold without limit.
// - Probe stop holds until path opens (closes with switch 2 on) and restart delay expires.
// - Probe default delay is three minutes; switches 3 or 4 override.
// - Output power below the low-power set point stops the pump.
// - Set-point adjust at minimum gives lowest set point, cutoff disabled.
// - Output power ceiling comes from the speed-control adjust input.
// - Low-power stop latches; cleared by run switch off then on.
// - Switch 7 on at power-up shows only startup screen until off.
`timescale 1ns/10ps
`default_nettype none

module ppr_run_permit #(
  parameter int TICK_CYCLES = ppr_pkg::TICK_CYCLES
) (
  input  wire logic                      I_CLK,
  input  wire logic                      I_NRST,
  input  wire logic [7:0]                I_CONFIG_SW,
  input  wire logic                      I_REMOTE_CLOSED,
  input  wire logic                      I_PROBE_CLOSED,
  input  wire logic                      I_OVER_CURRENT,
  input  wire logic                      I_RUN_SWITCH,
  input  wire logic [ppr_pkg::ADC_W-1:0] I_OUTPUT_POWER,
  input  wire logic [ppr_pkg::ADC_W-1:0] I_CUTOFF_SETPOINT_ADJUST,
  input  wire logic [ppr_pkg::ADC_W-1:0] I_SPEED_ADJUST,
  output logic                           O_MOTOR_RUN,
  output logic [ppr_pkg::ADC_W-1:0]      O_POWER_LIMIT,
  output logic                           O_ERROR_LED,
  output logic                           O_EXT_STOP_LED,
  output logic                           O_LOW_POWER_LED,
  output logic [2:0]                     O_SCREEN,
  output logic [1:0]                     O_STATUS_MSG
);
  import ppr_pkg::*;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  // Assert at once, release after two clean edges
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  logic rst_n;
  assign rst_n = rst_sync_reg;

  // ---------------------------------------------------------------
  // Shared one-second time base for display and start grace
  // ---------------------------------------------------------------
  logic [PRE_W-1:0] tick_pre_reg;
  logic             tick;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tick_pre_reg <= '0;
    end else if (tick_pre_reg == PRE_LAST) begin
      tick_pre_reg <= '0;
    end else begin
      tick_pre_reg <= tick_pre_reg + PRE_W'(1);
    end
  end

  assign tick = (tick_pre_reg == PRE_LAST);

  // ---------------------------------------------------------------
  // External stop conditions
  // ---------------------------------------------------------------
  logic remote_stop;
  logic probe_stop;
  logic ext_stop;

  // Switch 5, 6 and 8 are deliberately not decoded
  assign remote_stop = I_CONFIG_SW[SW_REMOTE_POL] ? !I_REMOTE_CLOSED
                                                  : I_REMOTE_CLOSED;
  assign probe_stop  = I_CONFIG_SW[SW_PROBE_POL] ? !I_PROBE_CLOSED
                                                 : I_PROBE_CLOSED;
  assign ext_stop    = remote_stop | probe_stop;

  // Remember that a stop was seen, and whether the probe caused it
  logic ext_seen_reg;
  logic probe_seen_reg;
  ppr_state_t state_reg;
  ppr_state_t state_next;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ext_seen_reg   <= 1'b0;
      probe_seen_reg <= 1'b0;
    end else if (ext_stop) begin
      ext_seen_reg   <= 1'b1;
      probe_seen_reg <= probe_stop | (probe_seen_reg & remote_stop);
    end else if (state_next == ST_RUN) begin
      ext_seen_reg   <= 1'b0;
      probe_seen_reg <= 1'b0;
    end
  end

  // Restart delay: longest selection wins over the source default
  logic [SEC_W-1:0] restart_sec;

  always_comb begin
    if (I_CONFIG_SW[SW_DLY_30]) begin
      restart_sec = DLY_SW4_SEC;
    end else if (I_CONFIG_SW[SW_DLY_10]) begin
      restart_sec = DLY_SW3_SEC;
    end else if (probe_seen_reg) begin
      restart_sec = DLY_PROBE_SEC;
    end else begin
      restart_sec = DLY_REMOTE_SEC;
    end
  end

  // ---------------------------------------------------------------
  // Low-power cutoff with start grace and latched fault
  // ---------------------------------------------------------------
  logic             run_sw_d_reg;
  logic             run_sw_rise;
  logic [3:0]       grace_reg;
  logic             lp_trip;
  logic             lp_fault_reg;
  logic [ADC_W-1:0] lp_setpoint;

  // Trim at its minimum gives set point zero: nothing is below it
  assign lp_setpoint = I_CUTOFF_SETPOINT_ADJUST;
  assign run_sw_rise = I_RUN_SWITCH & !run_sw_d_reg;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      run_sw_d_reg <= 1'b0;
    end else begin
      run_sw_d_reg <= I_RUN_SWITCH;
    end
  end

  // Seconds of running; power is judged only after the grace
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      grace_reg <= '0;
    end else if (state_reg != ST_RUN) begin
      grace_reg <= '0;
    end else if (tick && grace_reg != LP_GRACE_SEC) begin
      grace_reg <= grace_reg + 4'h1;
    end
  end

  assign lp_trip = (state_reg == ST_RUN) && (grace_reg == LP_GRACE_SEC)
                   && (I_OUTPUT_POWER < lp_setpoint);

  // Trip wins over a simultaneous run switch reset
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      lp_fault_reg <= 1'b0;
    end else if (lp_trip) begin
      lp_fault_reg <= 1'b1;
    end else if (run_sw_rise) begin
      lp_fault_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Run permit state machine and its shared hold timer
  // ---------------------------------------------------------------
  logic             timer_load;
  logic [SEC_W-1:0] timer_sec;
  logic             timer_busy;
  logic             permit;

  assign permit = I_RUN_SWITCH & !ext_stop & !lp_fault_reg;

  always_comb begin
    state_next = state_reg;
    timer_load = 1'b0;
    timer_sec  = restart_sec;
    unique case (state_reg)
      ST_STOPPED: begin
        if (permit && ext_seen_reg) begin
          state_next = ST_DELAY;
          timer_load = 1'b1;
        end else if (permit) begin
          state_next = ST_RUN;
        end
      end
      ST_DELAY: begin
        if (!permit) begin
          state_next = ST_STOPPED;
        end else if (!timer_busy) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!permit || lp_trip) begin
          state_next = ST_STOPPED;
        end else if (I_OVER_CURRENT) begin
          state_next = ST_OC_HOLD;
          timer_load = 1'b1;
          timer_sec  = OC_HOLD_SEC;
        end
      end
      ST_OC_HOLD: begin
        if (!permit) begin
          state_next = ST_STOPPED;
        end else if (!timer_busy) begin
          state_next = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_STOPPED;
    end else begin
      state_reg <= state_next;
    end
  end

  ppr_hold_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_hold_timer (
    .i_clk      (I_CLK),
    .i_rst_n    (rst_n),
    .i_load     (timer_load),
    .i_load_sec (timer_sec),
    .o_busy     (timer_busy)
  );

  // ---------------------------------------------------------------
  // Display screen stepping, freeze and startup lock
  // ---------------------------------------------------------------
  logic       first_reg;
  logic       boot_lock_reg;
  logic [3:0] step_reg;
  logic [2:0] screen_reg;
  logic       freeze;

  assign freeze = I_CONFIG_SW[SW_FREEZE];

  // Switch 7 is caught on the first edge after reset release
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      first_reg     <= 1'b1;
      boot_lock_reg <= 1'b0;
    end else if (first_reg) begin
      first_reg     <= 1'b0;
      boot_lock_reg <= freeze;
    end else if (!freeze) begin
      boot_lock_reg <= 1'b0;
    end
  end

  // Step seconds counter and screen index
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      step_reg   <= '0;
      screen_reg <= SCR_STARTUP;
    end else if (first_reg || boot_lock_reg) begin
      step_reg   <= '0;
      screen_reg <= SCR_STARTUP;
    end else if (freeze) begin
      step_reg   <= '0;
    end else if (tick) begin
      if (step_reg == SCREEN_STEP_SEC - 4'h1) begin
        step_reg   <= '0;
        screen_reg <= (screen_reg >= SCR_LAST) ? SCR_FIRST
                                               : screen_reg + 3'h1;
      end else begin
        step_reg <= step_reg + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic [1:0] msg_next;

  always_comb begin
    if (state_reg == ST_OC_HOLD) begin
      msg_next = MSG_OVER_CUR;
    end else if (lp_fault_reg) begin
      msg_next = MSG_LOW_PWR;
    end else if (ext_stop) begin
      msg_next = MSG_EXT_STOP;
    end else begin
      msg_next = MSG_NONE;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_MOTOR_RUN     <= 1'b0;
      O_POWER_LIMIT   <= '0;
      O_ERROR_LED     <= 1'b0;
      O_EXT_STOP_LED  <= 1'b0;
      O_LOW_POWER_LED <= 1'b0;
      O_SCREEN        <= SCR_STARTUP;
      O_STATUS_MSG    <= MSG_NONE;
    end else begin
      O_MOTOR_RUN     <= (state_reg == ST_RUN);
      O_POWER_LIMIT   <= I_SPEED_ADJUST;
      O_ERROR_LED     <= (state_reg == ST_OC_HOLD);
      O_EXT_STOP_LED  <= ext_stop;
      O_LOW_POWER_LED <= lp_fault_reg;
      O_SCREEN        <= screen_reg;
      O_STATUS_MSG    <= msg_next;
    end
  end

endmodule : ppr_run_permit

`default_nettype wire

// >>> ppr_contact_model.sv
// Far-side model: tank float or pressure switch and water probe contact
`timescale 1ns/10ps
`default_nettype none

module ppr_contact_model (
  input  wire logic i_clk,
  input  wire logic i_tank_high,
  input  wire logic i_probe_wet,
  input  wire logic i_nc_type,
  output logic      o_remote_closed,
  output logic      o_probe_closed
);
  // Contacts settle just after the edge, like a real switch bounce-free
  always_ff @(posedge i_clk) begin
    o_remote_closed <= i_tank_high ^ i_nc_type; // N.O. closes, N.C. opens
    o_probe_closed  <= i_probe_wet;             // Wet electrode to ground
  end
endmodule : ppr_contact_model

`default_nettype wire

// >>> ppr_run_permit_asserts.sv
// Concurrent checks on the run permit supervisor ports
`timescale 1ns/10ps
`default_nettype none

module ppr_run_permit_chk
  import ppr_pkg::*;
#(
  parameter int TICK_CYCLES = ppr_pkg::TICK_CYCLES
) (
  input wire logic             I_CLK,
  input wire logic             I_NRST,
  input wire logic [7:0]       I_CONFIG_SW,
  input wire logic             I_REMOTE_CLOSED,
  input wire logic             I_PROBE_CLOSED,
  input wire logic             I_OVER_CURRENT,
  input wire logic             I_RUN_SWITCH,
  input wire logic [ADC_W-1:0] I_OUTPUT_POWER,
  input wire logic [ADC_W-1:0] I_CUTOFF_SETPOINT_ADJUST,
  input wire logic [ADC_W-1:0] I_SPEED_ADJUST,
  input wire logic             O_MOTOR_RUN,
  input wire logic [ADC_W-1:0] O_POWER_LIMIT,
  input wire logic             O_ERROR_LED,
  input wire logic             O_EXT_STOP_LED,
  input wire logic             O_LOW_POWER_LED,
  input wire logic [2:0]       O_SCREEN,
  input wire logic [1:0]       O_STATUS_MSG
);
  localparam longint HOLD = longint'(OC_HOLD_SEC) * TICK_CYCLES;
  logic [2:0] up_cnt_reg;
  longint     err_cnt_reg;
  logic       live;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  // Settled flag: internal reset copy has released and outputs updated
  assign live = (up_cnt_reg == 3'h5);
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) up_cnt_reg <= 3'h0;
    else if (!live) up_cnt_reg <= up_cnt_reg + 3'h1;
  end

  // Length of the current over-current hold, in cycles
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) err_cnt_reg <= 0;
    else err_cnt_reg <= O_ERROR_LED ? err_cnt_reg + 1 : 0;
  end

  // Stop light one edge after the input, motor off one edge later
  sequence s_ext_stopped;
    ##1 O_EXT_STOP_LED ##1 !O_MOTOR_RUN;
  endsequence
  property p_remote_stop;
    live && (I_REMOTE_CLOSED != I_CONFIG_SW[SW_REMOTE_POL]) |-> s_ext_stopped;
  endproperty
  a_remote_stop: assert property (p_remote_stop)
    else $error("remote contact stop not obeyed");
  property p_probe_stop;
    live && (I_PROBE_CLOSED != I_CONFIG_SW[SW_PROBE_POL]) |-> s_ext_stopped;
  endproperty
  a_probe_stop: assert property (p_probe_stop)
    else $error("probe stop not obeyed");
  property p_limit;
    live |-> O_POWER_LIMIT == $past(I_SPEED_ADJUST);
  endproperty
  a_limit: assert property (p_limit)
    else $error("power limit does not follow speed adjust");
  property p_oc_cause;
    live && $rose(O_ERROR_LED) |-> $past(I_OVER_CURRENT, 2);
  endproperty
  a_oc_cause: assert property (p_oc_cause)
    else $error("error light without over-current");
  property p_oc_show;
    O_ERROR_LED |-> !O_MOTOR_RUN && O_STATUS_MSG == MSG_OVER_CUR;
  endproperty
  a_oc_show: assert property (p_oc_show)
    else $error("over-current hold shown wrongly");
  property p_oc_len;
    O_ERROR_LED |-> err_cnt_reg <= HOLD;
  endproperty
  a_oc_len: assert property (p_oc_len)
    else $error("over-current hold too long");
  property p_lp_stop;
    live && $rose(O_LOW_POWER_LED) |-> ##[0:2] !O_MOTOR_RUN;
  endproperty
  a_lp_stop: assert property (p_lp_stop)
    else $error("low power fault left motor running");
  property p_lp_off;
    live && $rose(O_LOW_POWER_LED) |-> $past(I_CUTOFF_SETPOINT_ADJUST, 2) != '0;
  endproperty
  a_lp_off: assert property (p_lp_off)
    else $error("low power trip with cutoff disabled");
  property p_lp_latch;
    O_LOW_POWER_LED && !I_RUN_SWITCH |=> O_LOW_POWER_LED;
  endproperty
  a_lp_latch: assert property (p_lp_latch)
    else $error("low power fault cleared without run switch");
  property p_freeze;
    live && $past(I_CONFIG_SW[SW_FREEZE], 2) && $past(I_CONFIG_SW[SW_FREEZE])
      |-> $stable(O_SCREEN);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("screen moved while frozen");
  property p_scr_range;
    O_SCREEN <= SCR_LAST;
  endproperty
  a_scr_range: assert property (p_scr_range)
    else $error("screen index out of range");
endmodule : ppr_run_permit_chk

bind ppr_run_permit ppr_run_permit_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
  .I_CLK(I_CLK), .I_NRST(I_NRST), .I_CONFIG_SW(I_CONFIG_SW),
  .I_REMOTE_CLOSED(I_REMOTE_CLOSED), .I_PROBE_CLOSED(I_PROBE_CLOSED),
  .I_OVER_CURRENT(I_OVER_CURRENT), .I_RUN_SWITCH(I_RUN_SWITCH),
  .I_OUTPUT_POWER(I_OUTPUT_POWER), .I_SPEED_ADJUST(I_SPEED_ADJUST),
  .I_CUTOFF_SETPOINT_ADJUST(I_CUTOFF_SETPOINT_ADJUST),
  .O_MOTOR_RUN(O_MOTOR_RUN), .O_POWER_LIMIT(O_POWER_LIMIT),
  .O_ERROR_LED(O_ERROR_LED), .O_EXT_STOP_LED(O_EXT_STOP_LED),
  .O_LOW_POWER_LED(O_LOW_POWER_LED), .O_SCREEN(O_SCREEN),
  .O_STATUS_MSG(O_STATUS_MSG));

`default_nettype wire

// >>> ppr_run_permit_test.sv
// Self-checking bench for the pump run permit supervisor
`timescale 1ns/10ps
`default_nettype none

module ppr_run_permit_test;
  import ppr_pkg::*;
  localparam int TK = 4;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  sw = 8'h00;
  logic        tank = 1'b0;
  logic        wet = 1'b0;
  logic        oc = 1'b0;
  logic        run_sw = 1'b0;
  logic [11:0] pwr = 12'h800;
  logic [11:0] lp = 12'h000;
  logic [11:0] spd = 12'h000;
  wire logic   remote, probe, o_run, o_err, o_ext, o_lp;
  wire logic [11:0] o_lim;
  wire logic [2:0]  o_scr;
  wire logic [1:0]  o_msg;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;

  always #10 clk = ~clk;

  ppr_contact_model i_sw (.i_clk(clk), .i_tank_high(tank),
    .i_probe_wet(wet), .i_nc_type(sw[0]), .o_remote_closed(remote),
    .o_probe_closed(probe));
  ppr_run_permit #(.TICK_CYCLES(TK)) i_dut (.I_CLK(clk), .I_NRST(nrst),
    .I_CONFIG_SW(sw), .I_REMOTE_CLOSED(remote), .I_PROBE_CLOSED(probe),
    .I_OVER_CURRENT(oc), .I_RUN_SWITCH(run_sw), .I_OUTPUT_POWER(pwr),
    .I_CUTOFF_SETPOINT_ADJUST(lp), .I_SPEED_ADJUST(spd),
    .O_MOTOR_RUN(o_run), .O_POWER_LIMIT(o_lim), .O_ERROR_LED(o_err),
    .O_EXT_STOP_LED(o_ext), .O_LOW_POWER_LED(o_lp), .O_SCREEN(o_scr),
    .O_STATUS_MSG(o_msg));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : step
  // Wait until the run output reaches a level, counting cycles
  task automatic wait_run(input logic lvl, output int m);
    m = 0;
    while (o_run !== lvl && m < 9000) begin
      step(1);
      m++;
    end
  endtask : wait_run
  task automatic do_reset();
    nrst = 1'b0;
    step(3);
    nrst = 1'b1;
    step(4);
  endtask : do_reset

  // Tank contact in both polarities, delay and a restart of the delay
  task automatic t_contacts();
    for (int p = 0; p < 2; p++) begin
      sw = 8'(p);
      wait_run(1'b1, n);
      tank = 1'b1;
      step(4);
      check(o_run, 1'b0);
      check(o_ext, 1'b1);
      check(o_msg, MSG_EXT_STOP);
      tank = 1'b0;
      step(100);
      tank = 1'b1;
      step(4);
      tank = 1'b0;
      wait_run(1'b1, n);
      check(n >= 60 * TK && n <= 60 * TK + 6, 1'b1);
      check(o_ext, 1'b0);
    end
    $display("contacts done");
  endtask : t_contacts

  // Probe stop under each delay selection
  task automatic t_delays();
    logic [7:0] sel [4] = '{8'h00, 8'h04, 8'h08, 8'h0e};
    int mins [4] = '{3, 10, 30, 30};
    for (int i = 0; i < 4; i++) begin
      sw = sel[i];
      wet = ~sw[1];
      step(4);
      check(o_run, 1'b0);
      wet = sw[1];
      wait_run(1'b1, n);
      check(n >= mins[i] * 60 * TK && n <= mins[i] * 60 * TK + 6, 1'b1);
    end
    sw = 8'h00;
    wet = 1'b0;
    // Closed probe seen once with switch 2 off: a short probe stop
    step(4);
    check(o_run, 1'b0);
    wait_run(1'b1, n);
    check(n >= 180 * TK - 4 && n <= 180 * TK + 2, 1'b1);
    $display("delays done");
  endtask : t_delays

  // Over-current hold, message and repeated retries
  task automatic t_over_current();
    oc = 1'b1;
    step(3);
    check(o_err, 1'b1);
    check(o_msg, MSG_OVER_CUR);
    check(o_run, 1'b0);
    n = 0;
    while (o_err === 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    check(n >= 180 * TK && n <= 180 * TK + 2, 1'b1);
    step(4);
    check(o_err, 1'b1);
    oc = 1'b0;
    wait_run(1'b1, n);
    check(o_run, 1'b1);
    check(o_err, 1'b0);
    $display("over-current done");
  endtask : t_over_current

  // Low power cutoff disabled, tripped, latched and cleared; power limit
  task automatic t_low_power();
    spd = 12'h5a3;
    pwr = 12'h000;
    step(60);
    check(o_lp, 1'b0);
    check(o_lim, 12'h5a3);
    lp = 12'h100;
    pwr = 12'h080;
    step(30);
    check(o_lp, 1'b1);
    check(o_run, 1'b0);
    check(o_msg, MSG_LOW_PWR);
    pwr = 12'h800;
    run_sw = 1'b0;
    step(6);
    check(o_lp, 1'b1);
    run_sw = 1'b1;
    step(6);
    check(o_lp, 1'b0);
    wait_run(1'b1, n);
    check(n < 10, 1'b1);
    $display("low power done");
  endtask : t_low_power

  // Screen stepping, freeze, and freeze at power-up
  task automatic t_screen();
    logic [2:0] s;
    for (int k = 0; k < 7; k++) begin
      s = o_scr;
      n = 0;
      while (o_scr === s && n < 40) begin
        step(1);
        n++;
      end
      check(o_scr, (s == SCR_LAST) ? SCR_FIRST : s + 3'h1);
      if (k > 0) check(n, 3 * TK);
    end
    sw[SW_FREEZE] = 1'b1;
    s = o_scr;
    step(50);
    check(o_scr, s);
    do_reset();
    step(60);
    check(o_scr, SCR_STARTUP);
    sw[SW_FREEZE] = 1'b0;
    step(3 * TK + 4);
    check(o_scr, SCR_FIRST);
    $display("screen done");
  endtask : t_screen

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  // Cycle ceiling well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 45000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    do_reset();
    run_sw = 1'b1;
    wait_run(1'b1, n);
    check(o_run, 1'b1);
    t_contacts();
    t_delays();
    t_over_current();
    t_low_power();
    t_screen();
    summarize();
  end
endmodule : ppr_run_permit_test

`default_nettype wire
